// File: core/counter_defs.svh
// register offsets, field positions, reset values and divider settings of the cascaded counter
`ifndef COUNTER_DEFS_SVH
`define COUNTER_DEFS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define OFS_CTRL        8'h00
`define OFS_CMP_LOW     8'h04
`define OFS_CMP_HIGH    8'h08
`define OFS_DUTY_LOW    8'h0c
`define OFS_DUTY_HIGH   8'h10
`define OFS_STATUS      8'h14

// ---------------------------------------------------------------
// control field positions and reset values
// ---------------------------------------------------------------
`define CTRL_RUN        0
`define CTRL_PWM        1
`define CTRL_INIT       2
`define CTRL_SRC_LO     4
`define CTRL_SRC_HI     6
`define STATUS_FLOP     16
`define CTRL_RESET      6'h00
`define BYTE_ZERO       8'h00
`define WORD16_ZERO     16'h0000
`define WORD16_ONE      16'h0001
`define WORD16_FULL     16'hffff
`define RDATA_ZERO      32'h0000_0000

// ---------------------------------------------------------------
// source select codes and prescaler masks
// ---------------------------------------------------------------
`define SRC_EXTERNAL    3'h0
`define DIV_WIDTH       11
`define MASK_DIV1       11'h000
`define MASK_DIV2       11'h001
`define MASK_DIV8       11'h007
`define MASK_DIV32      11'h01f
`define MASK_DIV128     11'h07f
`define MASK_DIV2048    11'h7ff

`endif

// File: core/counter_pkg.sv
// types shared by the cascaded event and pwm counter
package counter_pkg;

	// ---------------------------------------------------------------
	// bus address phase as captured for the data phase
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic       write;
		logic       active;
	} bus_phase_type;

	// ---------------------------------------------------------------
	// control register fields
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [2:0] src;
		logic       init_level;
		logic       pwm_mode;
		logic       run;
	} ctrl_type;

	typedef enum logic [1:0] {
		mode_event = 2'b01,
		mode_pwm   = 2'b10
	} count_mode_type;

endpackage : counter_pkg

// File: core/fall_edge_detect.sv
// one-cycle pulse on each falling edge of the event input pin
`timescale 1ns/1ps
module fall_edge_detect (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic level,
	output logic      fall_pulse
);
	logic prev;
	logic next_pulse;

	// the pin is taken as synchronous; a level shorter than one cycle may be missed
	always_comb begin
		next_pulse = prev & ~level;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prev       <= 1'b1;
			fall_pulse <= 1'b0;
		end else begin
			prev       <= level;
			fall_pulse <= next_pulse;
		end
	end
endmodule : fall_edge_detect

// File: core/clock_prescaler.sv
// free-running divider giving one tick per selected internal clock period
`include "counter_defs.svh"
`timescale 1ns/1ps
module clock_prescaler #(
	parameter int DIV_BITS = `DIV_WIDTH
) (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic [2:0] src,
	output logic            tick
);
	logic [DIV_BITS-1:0] div;
	logic [DIV_BITS-1:0] next_div;
	logic                next_tick;

	function automatic logic [DIV_BITS-1:0] src_mask(input logic [2:0] sel);
		case (sel)
			3'h1:    src_mask = DIV_BITS'(`MASK_DIV1);
			3'h2:    src_mask = DIV_BITS'(`MASK_DIV2);
			3'h3:    src_mask = DIV_BITS'(`MASK_DIV8);
			3'h4:    src_mask = DIV_BITS'(`MASK_DIV32);
			3'h5:    src_mask = DIV_BITS'(`MASK_DIV128);
			default: src_mask = DIV_BITS'(`MASK_DIV2048);
		endcase
	endfunction : src_mask

	always_comb begin
		next_div  = div + DIV_BITS'(1);
		next_tick = (src != `SRC_EXTERNAL) && ((div & src_mask(src)) == src_mask(src));
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div  <= '0;
			tick <= 1'b0;
		end else begin
			div  <= next_div;
			tick <= next_tick;
		end
	end
endmodule : clock_prescaler

// File: core/cascaded_event_pwm_counter.sv
// cascaded 16-bit event counter and pwm generator behind an ahb-lite register slave
//
// The AHB-Lite register port and the register offsets were left to the implementer.
`include "counter_defs.svh"
`timescale 1ns/1ps

module cascaded_event_pwm_counter (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        event_input_pin,
	output logic             pwm_output_pin,
	output logic             upper_counter_irq
);
	import counter_pkg::*;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	bus_phase_type  phase;
	bus_phase_type  next_phase;
	ctrl_type       ctrl;
	ctrl_type       next_ctrl;
	ctrl_type       wr_ctrl;
	logic [15:0]    compare;
	logic [15:0]    next_compare;
	logic [15:0]    duty;
	logic [15:0]    next_duty;
	logic [15:0]    shadow;
	logic [15:0]    next_shadow;
	logic [7:0]     count_low;
	logic [7:0]     count_high;
	logic [7:0]     next_count_low;
	logic [7:0]     next_count_high;
	logic           output_toggle_flop;
	logic           next_flop;
	logic           next_pin;
	logic           next_irq;
	logic [31:0]    next_rdata;
	logic [16:0]    stepped;
	logic [15:0]    count;
	logic           fall_pulse;
	logic           prescale_tick;
	logic           pwm_tick;
	logic           bus_write;
	logic           ctrl_write;
	count_mode_type mode;

	assign count     = {count_high, count_low};
	assign mode      = ctrl.pwm_mode ? mode_pwm : mode_event;
	assign bus_write = phase.active && phase.write;
	assign ctrl_write = bus_write && (phase.addr == `OFS_CTRL);
	assign wr_ctrl   = ctrl_type'({hwdata[`CTRL_SRC_HI:`CTRL_SRC_LO], hwdata[`CTRL_INIT:`CTRL_RUN]});
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// ---------------------------------------------------------------
	// event edge and internal clock sources
	// ---------------------------------------------------------------
	fall_edge_detect edge_det (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.level      (event_input_pin),
		.fall_pulse (fall_pulse)
	);

	clock_prescaler prescaler (
		.hclk    (hclk),
		.hresetn (hresetn),
		.src     (ctrl.src),
		.tick    (prescale_tick)
	);

	assign pwm_tick = (ctrl.src == `SRC_EXTERNAL) ? fall_pulse : prescale_tick;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// two 8-bit counters: the low byte carry steps the high byte
	function automatic logic [16:0] cascade_step(input logic [7:0] lo, input logic [7:0] hi);
		logic [8:0] lo_sum;
		logic [8:0] hi_sum;
		lo_sum = {1'b0, lo} + 9'h001;
		hi_sum = {1'b0, hi} + {8'h00, lo_sum[8]};
		cascade_step = {hi_sum[8], hi_sum[7:0], lo_sum[7:0]};
	endfunction : cascade_step

	function automatic logic [31:0] read_mux(input logic [7:0] addr);
		read_mux = `RDATA_ZERO;
		if (addr == `OFS_CTRL) begin
			read_mux = {25'h0, ctrl.src, 1'b0, ctrl.init_level, ctrl.pwm_mode, ctrl.run};
		end else if (addr == `OFS_CMP_LOW) begin
			read_mux = {24'h0, compare[7:0]};
		end else if (addr == `OFS_CMP_HIGH) begin
			read_mux = {24'h0, compare[15:8]};
		end else if (addr == `OFS_DUTY_LOW) begin
			read_mux = {24'h0, duty[7:0]};
		end else if (addr == `OFS_DUTY_HIGH) begin
			read_mux = {24'h0, duty[15:8]};
		end else if (addr == `OFS_STATUS) begin
			read_mux = {15'h0, output_toggle_flop, count};
		end
	endfunction : read_mux

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		next_phase      = '{addr: haddr[7:0], write: hwrite, active: hsel && htrans[1] && hready};
		next_rdata      = hrdata;
		next_ctrl       = ctrl;
		next_compare    = compare;
		next_duty       = duty;
		next_shadow     = shadow;
		next_count_low  = count_low;
		next_count_high = count_high;
		next_flop       = output_toggle_flop;
		next_irq        = 1'b0;
		stepped         = cascade_step(count_low, count_high);
		if (next_phase.active && !hwrite) begin
			next_rdata = read_mux(haddr[7:0]);
		end
		// counting engine
		if (ctrl.run) begin
			case (mode)
				mode_event: begin
					if (count == compare) begin
						next_irq        = 1'b1;
						next_count_low  = `BYTE_ZERO;
						next_count_high = `BYTE_ZERO;
					end else if (fall_pulse) begin
						{next_count_high, next_count_low} = stepped[15:0];
					end
				end
				mode_pwm: begin
					if (pwm_tick && stepped[16]) begin
						next_flop       = ~output_toggle_flop;
						next_irq        = 1'b1;
						next_count_low  = `BYTE_ZERO;
						next_count_high = `BYTE_ZERO;
						next_duty       = shadow;
					end else if (pwm_tick) begin
						{next_count_high, next_count_low} = stepped[15:0];
						if (stepped[15:0] == duty) begin
							next_flop = ~output_toggle_flop;
						end
					end
				end
				default: begin
					next_irq = 1'b0;
				end
			endcase
		end
		// register writes, in the data phase
		if (ctrl_write) begin
			next_ctrl = wr_ctrl;
			// a stop write leaves the flop alone; only a write made while stopped loads it
			if (!ctrl.run) begin
				next_flop = wr_ctrl.init_level;
			end
		end else if (bus_write && (phase.addr == `OFS_CMP_LOW)) begin
			next_compare[7:0] = hwdata[7:0];
		end else if (bus_write && (phase.addr == `OFS_CMP_HIGH)) begin
			next_compare[15:8] = hwdata[7:0];
		end else if (bus_write && (phase.addr == `OFS_DUTY_LOW)) begin
			next_shadow[7:0] = hwdata[7:0];
		end else if (bus_write && (phase.addr == `OFS_DUTY_HIGH)) begin
			next_shadow[15:8] = hwdata[7:0];
		end
		// a stopped or event-mode counter takes duty straight from the shadow
		if (!(ctrl.run && ctrl.pwm_mode) && bus_write &&
				((phase.addr == `OFS_DUTY_LOW) || (phase.addr == `OFS_DUTY_HIGH))) begin
			next_duty = next_shadow;
		end
		next_pin = ~next_flop;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase              <= '0;
			hrdata             <= `RDATA_ZERO;
			ctrl               <= ctrl_type'(`CTRL_RESET);
			compare            <= `WORD16_ZERO;
			duty               <= `WORD16_ZERO;
			shadow             <= `WORD16_ZERO;
			count_low          <= `BYTE_ZERO;
			count_high         <= `BYTE_ZERO;
			output_toggle_flop <= 1'b0;
			pwm_output_pin     <= 1'b1;
			upper_counter_irq  <= 1'b0;
		end else begin
			phase              <= next_phase;
			hrdata             <= next_rdata;
			ctrl               <= next_ctrl;
			compare            <= next_compare;
			duty               <= next_duty;
			shadow             <= next_shadow;
			count_low          <= next_count_low;
			count_high         <= next_count_high;
			output_toggle_flop <= next_flop;
			pwm_output_pin     <= next_pin;
			upper_counter_irq  <= next_irq;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking chk @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	logic [15:0] count_plus;
	assign count_plus = count + `WORD16_ONE;

	sequence s_wrap_cause;
		ctrl.run && ctrl.pwm_mode && pwm_tick && (count == `WORD16_FULL);
	endsequence

	sequence s_wrap_effect;
		upper_counter_irq && (count == `WORD16_ZERO) && (duty == $past(shadow));
	endsequence

	a_event_count_step: assert property (
		(ctrl.run && !ctrl.pwm_mode && fall_pulse && (count != compare)) |=> (count == $past(count_plus)))
		else $error("event edge did not advance the count by one");

	a_match_irq_clear: assert property (
		(ctrl.run && !ctrl.pwm_mode && (count == compare)) |=> (upper_counter_irq && (count == `WORD16_ZERO)))
		else $error("compare match did not raise interrupt and clear");

	a_resume_from_zero: assert property (
		(ctrl.run && !ctrl.pwm_mode && upper_counter_irq && !fall_pulse && !bus_write)
			|=> (count == `WORD16_ZERO))
		else $error("counter moved after a match without an event edge");

	a_cmp_immediate: assert property (
		(bus_write && (phase.addr == `OFS_CMP_LOW)) |=> (compare[7:0] == $past(hwdata[7:0])))
		else $error("compare low byte write not in effect at once");

	a_duty_match_toggle: assert property (
		(ctrl.run && ctrl.pwm_mode && pwm_tick && (count != `WORD16_FULL) && (count_plus == duty) && !ctrl_write)
			|=> (output_toggle_flop != $past(output_toggle_flop)) && (count == $past(count_plus)))
		else $error("duty match did not invert the flop or stopped counting");

	a_pwm_wrap: assert property (
		s_wrap_cause |=> s_wrap_effect)
		else $error("pwm overflow did not clear, interrupt and load duty");

	a_start_level: assert property (
		(ctrl_write && !ctrl.run) |=> (output_toggle_flop == $past(hwdata[`CTRL_INIT])))
		else $error("flop did not take the initial value bit");

	a_pin_inverse: assert property (
		pwm_output_pin == !output_toggle_flop)
		else $error("pwm pin is not the inverse of the toggle flop");

	a_stopped_hold: assert property (
		(!ctrl.run && !ctrl_write) ##1 (!ctrl.run && !ctrl_write) |=> $stable(pwm_output_pin))
		else $error("pwm pin moved while the counter was stopped");

	a_duty_direct: assert property (
		(!ctrl.run && bus_write && (phase.addr == `OFS_DUTY_HIGH)) |=> (duty == shadow))
		else $error("stopped duty write did not move across at once");
endmodule : cascaded_event_pwm_counter

// File: verif/event_source_model.sv
// external event pulse source driving the counter's event input
`timescale 1ns/1ps
module event_source_model (
	input  wire logic hclk,
	output logic      event_input_pin
);
	// ---------------------------------------------------------------
	// pulse train
	// ---------------------------------------------------------------
	initial event_input_pin = 1'b1;

	// each level stands three cycles, above the one-cycle floor
	task automatic send(input int n);
		for (int i = 0; i < n; i++) begin
			repeat (3) @(posedge hclk);
			event_input_pin <= 1'b0;
			repeat (3) @(posedge hclk);
			event_input_pin <= 1'b1;
		end
		repeat (4) @(posedge hclk);
	endtask : send
endmodule : event_source_model

// File: verif/cascaded_event_pwm_counter_bench.sv
// self-checking bench for the cascaded event and pwm counter
`include "counter_defs.svh"
`timescale 1ns/1ps
module cascaded_event_pwm_counter_bench;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        event_input_pin, pwm_output_pin, upper_counter_irq;
	int          err_total = 0;
	int          num_checks = 0;
	int          cycles = 0;
	int          irq_count = 0;

	cascaded_event_pwm_counter dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .event_input_pin(event_input_pin),
		.pwm_output_pin(pwm_output_pin), .upper_counter_irq(upper_counter_irq));

	event_source_model src (.hclk(hclk), .event_input_pin(event_input_pin));

	// ---------------------------------------------------------------
	// clock, interrupt tally, hang guard
	// ---------------------------------------------------------------
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end

	always @(posedge hclk) begin
		cycles <= cycles + 1;
		if (upper_counter_irq === 1'b1) irq_count <= irq_count + 1;
		// one full 16-bit pwm period is about 65.5k cycles, the rest is small
		if (cycles == 90000) begin
			err_total++;
			wrap_up();
		end
	end

	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : wrap_up

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic xfer(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		hwrite <= wr_en;
		htrans <= 2'b10;
		hsize <= 3'h2;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hsize <= 3'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask : xfer

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0000_0000);
		chk(what, exp, rd);
	endtask : rd_chk

	// bounded wait for the pwm pin to reach a level
	task automatic wait_pin(input logic lvl, input int lim);
		int n;
		n = 0;
		while (pwm_output_pin !== lvl && n < lim) begin
			@(posedge hclk);
			n++;
		end
		chk("pwm pin", {31'h0, lvl}, {31'h0, pwm_output_pin});
	endtask : wait_pin

	task automatic do_reset();
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
	endtask : do_reset

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic test_reset();
		chk("pwm pin", 32'h1, pwm_output_pin);
		chk("irq", 32'h0, upper_counter_irq);
		rd_chk("status", `OFS_STATUS, 32'h0);
		wr(8'h40, 32'hffff_ffff);
		chk("hresp", 32'h0, {31'h0, hresp});
		rd_chk("unmapped", 8'h40, 32'h0);
	endtask : test_reset

	task automatic test_event();
		int base;
		base = irq_count;
		wr(`OFS_CMP_LOW, 32'h02);
		wr(`OFS_CMP_HIGH, 32'h01);
		wr(`OFS_CTRL, 32'h01); // event mode, toggle level kept 0
		src.send(256);
		rd_chk("count", `OFS_STATUS, 32'h100);
		chk("irq", base, irq_count);
		src.send(2);
		chk("irq", base + 1, irq_count);
		rd_chk("count", `OFS_STATUS, 32'h0);
		src.send(1);
		rd_chk("count", `OFS_STATUS, 32'h1);
		wr(`OFS_CMP_LOW, 32'h03);
		wr(`OFS_CMP_HIGH, 32'h00);
		src.send(2);
		chk("irq", base + 2, irq_count);
		chk("pwm pin", 32'h1, pwm_output_pin);
		wr(`OFS_CTRL, 32'h00);
	endtask : test_event

	task automatic test_pwm();
		int base;
		wr(`OFS_CTRL, 32'h12);
		wr(`OFS_DUTY_LOW, 32'h20);
		wr(`OFS_DUTY_HIGH, 32'h00);
		rd_chk("duty", `OFS_DUTY_LOW, 32'h20);
		wr(`OFS_CTRL, 32'h13);
		wait_pin(1'b0, 60);
		xfer(1'b0, `OFS_STATUS, 32'h0);
		chk("flop", 32'h1, rd[16]);
		chk("no clear", 32'h1, rd[15:0] > 16'h20 && rd[15:0] < 16'h40);
		wr(`OFS_DUTY_LOW, 32'h40);
		wr(`OFS_DUTY_HIGH, 32'h00);
		rd_chk("duty", `OFS_DUTY_LOW, 32'h20);
		base = irq_count;
		for (int n = 0; n < 70000 && irq_count == base; n++) @(posedge hclk);
		chk("irq", base + 1, irq_count);
		chk("pwm pin", 32'h1, pwm_output_pin);
		rd_chk("duty", `OFS_DUTY_LOW, 32'h40);
		xfer(1'b0, `OFS_STATUS, 32'h0);
		chk("cleared", 32'h1, rd[15:0] < 16'h10);
		wait_pin(1'b0, 90);
		xfer(1'b0, `OFS_STATUS, 32'h0);
		chk("new duty", 32'h1, rd[15:0] > 16'h40 && rd[15:0] < 16'h50);
		// stopping must not touch the level, only a later write may
		wr(`OFS_CTRL, 32'h12);
		repeat (20) @(posedge hclk);
		chk("pwm pin", 32'h0, pwm_output_pin);
		wr(`OFS_CTRL, 32'h12);
		// the pin is launched by the data-phase edge, so look one edge later
		@(posedge hclk);
		chk("pwm pin", 32'h1, pwm_output_pin);
		wr(`OFS_CTRL, 32'h16);
		@(posedge hclk);
		chk("pwm pin", 32'h0, pwm_output_pin);
	endtask : test_pwm

	task automatic test_external();
		do_reset();
		wr(`OFS_CTRL, 32'h02);
		wr(`OFS_DUTY_LOW, 32'h03);
		wr(`OFS_DUTY_HIGH, 32'h00);
		wr(`OFS_CTRL, 32'h03);
		src.send(2);
		chk("pwm pin", 32'h1, pwm_output_pin);
		src.send(1);
		chk("pwm pin", 32'h0, pwm_output_pin);
	endtask : test_external

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		hresetn = 1'b0;
		do_reset();
		test_reset();
		test_event();
		test_pwm();
		test_external();
		wrap_up();
	end
endmodule : cascaded_event_pwm_counter_bench
